// >>> hdl/sscx_pkg.sv
/*
  shared types and constants for the swap / supervisor call / coprocessor
  execution block. assumes a 32-bit instruction word and a 4-bit flag vector.
*/
package sscx_pkg;

  // condition field and flag positions
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int FLAG_N  = 3;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_C  = 1;
  localparam int FLAG_V  = 0;

  // class field and decode patterns
  localparam int          CLASS_HI      = 27;
  localparam int          CLASS_LO      = 24;
  localparam logic [3:0]  CLASS_SVC     = 4'hf;
  localparam logic [3:0]  CLASS_COPROC  = 4'he;
  localparam int          COPROC_BIT    = 4;
  localparam logic [2:0]  COPROC_XFER   = 3'h6;
  localparam logic [4:0]  SWAP_TOP      = 5'h02;
  localparam logic [1:0]  SWAP_MID      = 2'h0;
  localparam logic [7:0]  SWAP_LOW      = 8'h09;
  localparam int          SWAP_BYTE_BIT = 22;
  localparam int          BASE_LO       = 16;
  localparam int          DEST_LO       = 12;
  localparam int          SRC_LO        = 0;

  // coprocessor data operation fields
  localparam int COPROC_SECOND_LO = 0;
  localparam int COPROC_INFO_LO   = 5;
  localparam int COPROC_NUMBER_LO = 8;
  localparam int COPROC_DEST_LO   = 12;
  localparam int COPROC_FIRST_LO  = 16;
  localparam int COPROC_OPCODE_LO = 20;

  // supervisor call vector, and link offsets for supervisor call and abort
  localparam logic [31:0] SVC_VECTOR  = 32'h0000_0008;
  localparam logic [31:0] NEXT_WORD   = 32'h0000_0004;
  localparam logic [31:0] ABORT_LINK  = 32'h0000_0008;

  typedef enum logic [1:0] {SSCX_CYC_NONE, SSCX_CYC_S, SSCX_CYC_N, SSCX_CYC_I} sscx_cyc_t;
  typedef enum logic [1:0] {SSCX_TRAP_NONE, SSCX_TRAP_SVC, SSCX_TRAP_UND, SSCX_TRAP_ABT} sscx_trap_t;

  // memory request group
  typedef struct packed {
    logic        req;
    logic        wr;
    logic        byte_sel;
    logic        lock;
    logic [3:0]  be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sscx_mem_t;

  // trap entry group
  typedef struct packed {
    logic        valid;
    sscx_trap_t  kind;
    logic [31:0] vector;
    logic [31:0] link;
    logic [31:0] saved;
  } sscx_trap_req_t;

endpackage

// >>> hdl/sscx_cond_check.sv
/*
  condition field evaluator for one instruction.
  assumes flags are presented stable while the instruction is offered.
*/
`timescale 1ns/100ps
module sscx_cond_check (
  input  wire logic [3:0] i_cond,
  input  wire logic [3:0] i_flags,
  output logic            o_pass
);
  logic n;
  logic z;
  logic c;
  logic v;

  assign n = i_flags[sscx_pkg::FLAG_N];
  assign z = i_flags[sscx_pkg::FLAG_Z];
  assign c = i_flags[sscx_pkg::FLAG_C];
  assign v = i_flags[sscx_pkg::FLAG_V];

  always_comb begin
    unique case (i_cond)
      4'h0: o_pass = z;
      4'h1: o_pass = !z;
      4'h2: o_pass = c;
      4'h3: o_pass = !c;
      4'h4: o_pass = n;
      4'h5: o_pass = !n;
      4'h6: o_pass = v;
      4'h7: o_pass = !v;
      4'h8: o_pass = c && !z;
      4'h9: o_pass = !c || z;
      4'ha: o_pass = (n == v);
      4'hb: o_pass = (n != v);
      4'hc: o_pass = !z && (n == v);
      4'hd: o_pass = z || (n != v);
      4'he: o_pass = 1'b1;
      4'hf: o_pass = 1'b0;
    endcase
  end
endmodule

// >>> hdl/sscx_lane_unit.sv
/*
  byte lane placement for the load and store halves of a swap.
  assumes the same placement as ordinary single loads and stores.
*/
`timescale 1ns/100ps
module sscx_lane_unit (
  input  wire logic [1:0]  i_addr,
  input  wire logic        i_big_endian,
  input  wire logic        i_byte,
  input  wire logic [31:0] i_rdata,
  input  wire logic [31:0] i_src,
  output logic [31:0]      o_load,
  output logic [31:0]      o_store,
  output logic [3:0]       o_be
);
  logic [1:0]  lane;
  logic [4:0]  lane_sh;
  logic [4:0]  rot_sh;
  logic [63:0] rot_word;
  logic [31:0] lane_word;

  assign lane      = i_big_endian ? ~i_addr : i_addr;
  assign lane_sh   = {lane, 3'h0};
  assign rot_sh    = {i_addr, 3'h0};
  assign rot_word  = {i_rdata, i_rdata} >> rot_sh;
  assign lane_word = i_rdata >> lane_sh;

  always_comb begin
    if (i_byte) begin
      o_load  = {24'h00_0000, lane_word[7:0]};
      o_store = {4{i_src[7:0]}};
      o_be    = 4'h1 << lane;
    end else begin
      o_load  = rot_word[31:0];
      o_store = i_src;
      o_be    = 4'hf;
    end
  end
endmodule

// >>> hdl/sscx_exec.sv
/*
  execution of the locked swap, the supervisor call and the coprocessor
  data operation class. assumes the core offers one instruction at a time
  while o_busy is low, with base and source register values alongside, and
  a memory that answers every data access in the cycle it is requested.

*/
`timescale 1ns/100ps
module sscx_exec #(
  parameter logic [31:0] UNDEF_VECTOR = 32'h0000_0004,
  parameter logic [31:0] ABORT_VECTOR = 32'h0000_0010
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_srst,
  input  wire logic                   i_instr_valid,
  input  wire logic [31:0]            i_instr,
  input  wire logic [31:0]            i_instr_addr,
  input  wire logic [3:0]             i_flags,
  input  wire logic [31:0]            i_current_status_register,
  input  wire logic [31:0]            i_base_register,
  input  wire logic [31:0]            i_source_register,
  input  wire logic                   i_big_endian,
  input  wire logic [31:0]            i_mem_rdata,
  input  wire logic                   i_mem_abort,
  output logic                        o_busy,
  output logic                        o_done,
  output logic                        o_irq_inhibit,
  output sscx_pkg::sscx_cyc_t         o_cycle_type,
  output logic                        o_mem_req,
  output logic                        o_mem_wr,
  output logic                        o_mem_byte,
  output logic                        o_mem_lock,
  output logic [3:0]                  o_mem_be,
  output logic [31:0]                 o_mem_addr,
  output logic [31:0]                 o_mem_wdata,
  output logic                        o_rd_we,
  output logic [3:0]                  o_rd_idx,
  output logic [31:0]                 o_rd_data,
  output logic                        o_trap_valid,
  output sscx_pkg::sscx_trap_t        o_trap_kind,
  output logic [31:0]                 o_trap_vector,
  output logic [31:0]                 o_supervisor_link_register,
  output logic [31:0]                 o_supervisor_saved_status
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_SWAP_RD, ST_SWAP_WR, ST_SWAP_INT, ST_SWAP_SEQ,
    ST_SVC_N, ST_SVC_S1, ST_SVC_S2, ST_UND_S
  } sscx_state_t;

  typedef struct packed {
    sscx_state_t             state;
    logic [31:0]             pc;
    logic [31:0]             status;
    logic [31:0]             src;
    logic [31:0]             load;
    logic [3:0]              dest;
    logic                    abort;
    logic                    busy;
    logic                    done;
    logic                    irq_inh;
    sscx_pkg::sscx_cyc_t     cyc;
    sscx_pkg::sscx_mem_t     mem;
    logic                    rd_we;
    logic [3:0]              rd_idx;
    logic [31:0]             rd_data;
    sscx_pkg::sscx_trap_req_t trap;
  } sscx_exec_st_t;

  sscx_exec_st_t s_q;
  sscx_exec_st_t s_d;

  logic        cond_pass;
  logic        accept;
  logic        is_swap;
  logic        is_svc;
  logic        is_coproc_data;
  logic        is_coproc;
  logic        abort_any;
  logic        lane_byte;
  logic [1:0]  lane_addr;
  logic [31:0] lane_load;
  logic [31:0] lane_store;
  logic [3:0]  lane_be;

  sscx_cond_check u_cond (
    .i_cond  (i_instr[sscx_pkg::COND_HI:sscx_pkg::COND_LO]),
    .i_flags (i_flags),
    .o_pass  (cond_pass)
  );

  // lanes follow the new instruction while idle, the latched swap otherwise
  assign lane_addr = (s_q.state == ST_IDLE) ? i_base_register[1:0] : s_q.mem.addr[1:0];
  assign lane_byte = (s_q.state == ST_IDLE) ? i_instr[sscx_pkg::SWAP_BYTE_BIT] : s_q.mem.byte_sel;

  sscx_lane_unit u_lane (
    .i_addr       (lane_addr),
    .i_big_endian (i_big_endian),
    .i_byte       (lane_byte),
    .i_rdata      (i_mem_rdata),
    .i_src        (s_q.src),
    .o_load       (lane_load),
    .o_store      (lane_store),
    .o_be         (lane_be)
  );

  // class decode
  assign is_swap = (i_instr[27:23] == sscx_pkg::SWAP_TOP) && (i_instr[21:20] == sscx_pkg::SWAP_MID)
                   && (i_instr[11:4] == sscx_pkg::SWAP_LOW);
  // comment field never reaches any logic
  assign is_svc = (i_instr[sscx_pkg::CLASS_HI:sscx_pkg::CLASS_LO] == sscx_pkg::CLASS_SVC);
  // only bit 4 and the class field, bits 27:24, are looked at
  assign is_coproc_data = (i_instr[sscx_pkg::CLASS_HI:sscx_pkg::CLASS_LO] == sscx_pkg::CLASS_COPROC)
                          && !i_instr[sscx_pkg::COPROC_BIT];
  assign is_coproc = (i_instr[sscx_pkg::CLASS_HI:sscx_pkg::CLASS_LO] == sscx_pkg::CLASS_COPROC)
                     || (i_instr[27:25] == sscx_pkg::COPROC_XFER);

  assign accept    = (s_q.state == ST_IDLE) && i_instr_valid;
  assign abort_any = s_q.abort || i_mem_abort;

  always_comb begin
    s_d             = s_q;
    s_d.done        = 1'b0;
    s_d.rd_we       = 1'b0;
    s_d.trap.valid  = 1'b0;
    s_d.mem.req     = 1'b0;
    s_d.mem.wr      = 1'b0;
    s_d.mem.lock    = 1'b0;
    s_d.cyc         = sscx_pkg::SSCX_CYC_NONE;
    unique case (s_q.state)
      ST_IDLE: begin
        if (accept) begin
          s_d.pc     = i_instr_addr;
          s_d.status = i_current_status_register;
          if (!cond_pass) begin
            s_d.done = 1'b1;
          end else if (is_swap) begin
            s_d.state        = ST_SWAP_RD;
            s_d.busy         = 1'b1;
            s_d.irq_inh      = 1'b1;
            s_d.abort        = 1'b0;
            s_d.src          = i_source_register;
            s_d.dest         = i_instr[sscx_pkg::DEST_LO +: 4];
            s_d.mem.req      = 1'b1;
            s_d.mem.addr     = i_base_register;
            s_d.mem.byte_sel = i_instr[sscx_pkg::SWAP_BYTE_BIT];
            s_d.mem.be       = lane_be;
            s_d.mem.lock     = 1'b1;
            s_d.cyc          = sscx_pkg::SSCX_CYC_N;
          end else if (is_svc) begin
            s_d.state       = ST_SVC_N;
            s_d.busy        = 1'b1;
            s_d.trap.valid  = 1'b1;
            s_d.trap.kind   = sscx_pkg::SSCX_TRAP_SVC;
            s_d.trap.vector = sscx_pkg::SVC_VECTOR;
            s_d.trap.saved  = i_current_status_register;
            s_d.trap.link   = i_instr_addr + sscx_pkg::NEXT_WORD;
            s_d.cyc         = sscx_pkg::SSCX_CYC_N;
          end else if (is_coproc || is_coproc_data) begin
            s_d.state = ST_UND_S;
            s_d.busy  = 1'b1;
            s_d.cyc   = sscx_pkg::SSCX_CYC_S;
          end else begin
            s_d.done = 1'b1;
          end
        end
      end
      ST_SWAP_RD: begin
        s_d.load      = lane_load;
        s_d.abort     = abort_any;
        s_d.state     = ST_SWAP_WR;
        s_d.mem.req   = 1'b1;
        s_d.mem.wr    = 1'b1;
        s_d.mem.wdata = lane_store;
        s_d.mem.be    = lane_be;
        s_d.mem.lock  = 1'b1;
        s_d.cyc       = sscx_pkg::SSCX_CYC_N;
      end
      ST_SWAP_WR: begin
        s_d.abort   = abort_any;
        s_d.state   = ST_SWAP_INT;
        s_d.irq_inh = 1'b0;
        s_d.cyc     = sscx_pkg::SSCX_CYC_I;
        if (!abort_any) begin
          s_d.rd_we   = 1'b1;
          s_d.rd_idx  = s_q.dest;
          s_d.rd_data = s_q.load;
        end
      end
      ST_SWAP_INT: begin
        s_d.state = ST_SWAP_SEQ;
        s_d.cyc   = sscx_pkg::SSCX_CYC_S;
        if (s_q.abort) begin
          s_d.trap.valid  = 1'b1;
          s_d.trap.kind   = sscx_pkg::SSCX_TRAP_ABT;
          s_d.trap.vector = ABORT_VECTOR;
          s_d.trap.saved  = s_q.status;
          s_d.trap.link   = s_q.pc + sscx_pkg::ABORT_LINK;
        end
      end
      ST_SWAP_SEQ: begin
        s_d.state = ST_IDLE;
        s_d.busy  = 1'b0;
        s_d.done  = 1'b1;
      end
      ST_SVC_N: begin
        s_d.state = ST_SVC_S1;
        s_d.cyc   = sscx_pkg::SSCX_CYC_S;
      end
      ST_SVC_S1: begin
        s_d.state = ST_SVC_S2;
        s_d.cyc   = sscx_pkg::SSCX_CYC_S;
      end
      ST_SVC_S2: begin
        s_d.state = ST_IDLE;
        s_d.busy  = 1'b0;
        s_d.done  = 1'b1;
      end
      ST_UND_S: begin
        // no handshake with any coprocessor, so no busy wait
        s_d.state       = ST_IDLE;
        s_d.busy        = 1'b0;
        s_d.done        = 1'b1;
        s_d.trap.valid  = 1'b1;
        s_d.trap.kind   = sscx_pkg::SSCX_TRAP_UND;
        s_d.trap.vector = UNDEF_VECTOR;
        s_d.trap.saved  = s_q.status;
        s_d.trap.link   = s_q.pc + sscx_pkg::NEXT_WORD;
      end
      default: begin
        s_d.state = ST_IDLE;
        s_d.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_busy                     = s_q.busy;
  assign o_done                     = s_q.done;
  assign o_irq_inhibit              = s_q.irq_inh;
  assign o_cycle_type               = s_q.cyc;
  assign o_mem_req                  = s_q.mem.req;
  assign o_mem_wr                   = s_q.mem.wr;
  assign o_mem_byte                 = s_q.mem.byte_sel;
  assign o_mem_lock                 = s_q.mem.lock;
  assign o_mem_be                   = s_q.mem.be;
  assign o_mem_addr                 = s_q.mem.addr;
  assign o_mem_wdata                = s_q.mem.wdata;
  assign o_rd_we                    = s_q.rd_we;
  assign o_rd_idx                   = s_q.rd_idx;
  assign o_rd_data                  = s_q.rd_data;
  assign o_trap_valid               = s_q.trap.valid;
  assign o_trap_kind                = s_q.trap.kind;
  assign o_trap_vector              = s_q.trap.vector;
  assign o_supervisor_link_register = s_q.trap.link;
  assign o_supervisor_saved_status  = s_q.trap.saved;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  cond_skip_a: assert property (accept && !cond_pass |=> o_done && !o_busy && !o_mem_req)
    else $error("failed condition still ran");
  swap_read_first_a: assert property (accept && cond_pass && is_swap |=> o_mem_req && !o_mem_wr
    && o_mem_addr == $past(i_base_register) ##1 o_mem_wr && o_mem_addr == $past(o_mem_addr))
    else $error("swap access order wrong");
  irq_hold_a: assert property (o_mem_lock |-> o_irq_inhibit)
    else $error("interrupt open inside locked swap");
  lock_span_a: assert property (s_q.state == ST_SWAP_RD |-> o_mem_lock ##1 o_mem_lock && o_mem_wr
    ##1 !o_mem_lock)
    else $error("lock not held over both accesses");
  byte_lane_a: assert property (o_mem_req && o_mem_byte |-> $onehot(o_mem_be))
    else $error("byte swap enables not one lane");
  load_back_a: assert property (s_q.state == ST_SWAP_WR && !abort_any |=> o_rd_we
    && o_rd_data == $past(s_q.load) && o_rd_idx == $past(s_q.dest))
    else $error("swap destination not loaded");
  abort_trap_a: assert property (s_q.state == ST_SWAP_WR && abort_any |=> !o_rd_we
    ##1 o_trap_valid && o_trap_kind == sscx_pkg::SSCX_TRAP_ABT)
    else $error("swap abort trap missing");
  swap_cycles_a: assert property (s_q.state == ST_SWAP_RD |-> o_cycle_type == sscx_pkg::SSCX_CYC_N
    ##1 o_cycle_type == sscx_pkg::SSCX_CYC_N ##1 o_cycle_type == sscx_pkg::SSCX_CYC_I
    ##1 o_cycle_type == sscx_pkg::SSCX_CYC_S ##1 o_done)
    else $error("swap cycle sequence wrong");
  svc_entry_a: assert property (accept && cond_pass && is_svc |=> o_trap_valid
    && o_trap_kind == sscx_pkg::SSCX_TRAP_SVC && o_trap_vector == sscx_pkg::SVC_VECTOR
    && o_supervisor_saved_status == $past(i_current_status_register)
    && o_supervisor_link_register == $past(i_instr_addr) + sscx_pkg::NEXT_WORD)
    else $error("supervisor call entry wrong");
  svc_cycles_a: assert property (accept && cond_pass && is_svc |=> o_cycle_type == sscx_pkg::SSCX_CYC_N
    ##1 o_cycle_type == sscx_pkg::SSCX_CYC_S [*2] ##1 o_done && !o_busy)
    else $error("supervisor call cycles wrong");
  undef_trap_a: assert property (accept && cond_pass && !is_swap && !is_svc
    && is_coproc_data |=> o_cycle_type == sscx_pkg::SSCX_CYC_S ##1 o_trap_valid
    && o_trap_kind == sscx_pkg::SSCX_TRAP_UND && !o_busy)
    else $error("coprocessor op did not trap");
  cond_quiet_a: assert property (accept && !cond_pass |=> !o_trap_valid && !o_rd_we)
    else $error("failed condition left a trace");
  irq_release_a: assert property (s_q.state == ST_SWAP_WR |=> !o_irq_inhibit && !o_mem_lock)
    else $error("interrupt still held after swap");
  req_locked_a: assert property (o_mem_req |-> o_mem_lock && o_busy)
    else $error("data access outside locked swap");
  word_lanes_a: assert property (o_mem_req && !o_mem_byte |-> o_mem_be == 4'hf)
    else $error("word swap enables not all lanes");
  word_source_a: assert property (s_q.state == ST_SWAP_RD && !s_q.mem.byte_sel |=> o_mem_wr
    && o_mem_wdata == $past(s_q.src))
    else $error("word swap wrote wrong data");
  byte_source_a: assert property (s_q.state == ST_SWAP_RD && s_q.mem.byte_sel |=> o_mem_wr
    && o_mem_wdata == {4{$past(s_q.src[7:0])}})
    else $error("byte swap wrote wrong data");
  svc_quiet_a: assert property (s_q.state == ST_SVC_N |-> !o_mem_req && !o_irq_inhibit)
    else $error("supervisor call touched the bus");
  undef_vector_a: assert property (o_trap_valid && o_trap_kind == sscx_pkg::SSCX_TRAP_UND
    |-> o_trap_vector == UNDEF_VECTOR && !o_busy && o_done)
    else $error("undefined trap entry wrong");

endmodule

// >>> verification/sscx_mem_model.sv
/*
  memory and memory manager model on the data port of sscx_exec.
  assumes zero-wait answers and aborts commanded by the bench.
*/
`timescale 1ns/100ps
module sscx_mem_model (
  input  wire logic        i_mclk,
  input  wire logic        i_req,
  input  wire logic        i_wr,
  input  wire logic [3:0]  i_be,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_abort_rd,
  input  wire logic        i_abort_wr,
  output logic [31:0]      o_rdata,
  output logic             o_abort
);
  logic [31:0] mem [16];
  logic [31:0] last_q = 32'h0;
  // no other master exists, so the bus never leaves this core while locked
  // abort on read, write or both as commanded
  assign o_abort = i_req & (i_wr ? i_abort_wr : i_abort_rd);
  // a released data line shows the inverse of the last value
  assign o_rdata = (i_req & ~i_wr) ? mem[i_addr[5:2]] : ~last_q;
  always @(posedge i_mclk) begin
    if (i_req & ~i_wr)
      last_q <= mem[i_addr[5:2]];
    for (int k = 0; k < 4; k++)
      if (i_req & i_wr & ~o_abort & i_be[k])
        mem[i_addr[5:2]][8*k+:8] <= i_wdata[8*k+:8];
  end
endmodule

// >>> verification/sscx_exec_test.sv
/*
  self-checking bench for sscx_exec with a memory model on its data port.
  assumes zero-wait memory and back-to-back takes in the done cycle.
*/
`timescale 1ns/100ps
module sscx_exec_test;
  localparam logic [31:0] UNDEF_VEC = 32'h0000_0004;
  localparam logic [31:0] ABORT_VEC = 32'h0000_0010;
  logic                 i_mclk = 1'b0;
  logic                 i_srst = 1'b1;
  logic                 i_instr_valid = 1'b0;
  logic                 i_big_endian = 1'b0;
  logic                 abort_rd = 1'b0;
  logic                 abort_wr = 1'b0;
  logic [3:0]           i_flags = 4'h0;
  logic [31:0]          i_instr = 32'h0;
  logic [31:0]          i_instr_addr = 32'h0;
  logic [31:0]          i_current_status_register = 32'h0;
  logic [31:0]          i_base_register = 32'h0;
  logic [31:0]          i_source_register = 32'h0;
  logic [31:0]          i_mem_rdata;
  logic                 i_mem_abort;
  logic                 o_busy, o_done, o_irq_inhibit, o_mem_req, o_mem_wr, o_mem_byte, o_mem_lock;
  logic                 o_rd_we, o_trap_valid;
  logic [3:0]           o_mem_be, o_rd_idx;
  logic [31:0]          o_mem_addr, o_mem_wdata, o_rd_data, o_trap_vector;
  logic [31:0]          o_supervisor_link_register, o_supervisor_saved_status;
  sscx_pkg::sscx_cyc_t  o_cycle_type;
  sscx_pkg::sscx_trap_t o_trap_kind;
  logic [97:0]          q[$];
  logic [31:0]          seed = 32'h24;
  int                   mismatches = 0;
  int                   samples_checked = 0;
  int                   cycles = 0;
  int                   dones = 0;
  int                   runs = 0;

  sscx_exec #(.UNDEF_VECTOR(UNDEF_VEC), .ABORT_VECTOR(ABORT_VEC)) uut (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_instr_addr(i_instr_addr), .i_flags(i_flags), .i_current_status_register(i_current_status_register),
    .i_base_register(i_base_register), .i_source_register(i_source_register), .i_big_endian(i_big_endian),
    .i_mem_rdata(i_mem_rdata), .i_mem_abort(i_mem_abort), .o_busy(o_busy), .o_done(o_done),
    .o_irq_inhibit(o_irq_inhibit), .o_cycle_type(o_cycle_type), .o_mem_req(o_mem_req), .o_mem_wr(o_mem_wr),
    .o_mem_byte(o_mem_byte), .o_mem_lock(o_mem_lock), .o_mem_be(o_mem_be), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_rd_we(o_rd_we), .o_rd_idx(o_rd_idx), .o_rd_data(o_rd_data),
    .o_trap_valid(o_trap_valid), .o_trap_kind(o_trap_kind), .o_trap_vector(o_trap_vector),
    .o_supervisor_link_register(o_supervisor_link_register),
    .o_supervisor_saved_status(o_supervisor_saved_status));

  sscx_mem_model u_mem (
    .i_mclk(i_mclk), .i_req(o_mem_req), .i_wr(o_mem_wr), .i_be(o_mem_be), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .i_abort_rd(abort_rd), .i_abort_wr(abort_wr), .o_rdata(i_mem_rdata),
    .o_abort(i_mem_abort));

  always #5 i_mclk = ~i_mclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // condition table, code 0 in the lowest bit
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    logic [15:0] t;
    {n, z, cy, v} = f;
    t = {1'b0, 1'b1, z | (n ^ v), ~z & ~(n ^ v), n ^ v, ~(n ^ v), ~cy | z, cy & ~z,
         ~v, v, ~n, n, ~cy, cy, ~z, z};
    return t[c];
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [97:0] got, input logic [97:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic prep();
    logic [31:0] r;
    r = rnd();
    i_instr_addr = {r[31:2], 2'h0};
    i_flags = r[3:0];
    i_current_status_register = rnd();
  endtask

  task automatic push_trap(input sscx_pkg::sscx_trap_t k, input logic [31:0] vec, input logic [31:0] off);
    q.push_back({2'(k), vec, i_instr_addr + off, i_current_status_register});
  endtask

  // offers one instruction, then records cycle type, lock and inhibit per cycle until done
  task automatic run(input logic [31:0] ins, input logic [15:0] exp_seq);
    logic [15:0] seq;
    logic bz;
    int n;
    seq = 16'h0;
    bz = 1'b1;
    n = 0;
    runs++;
    i_instr = ins;
    i_instr_valid = 1'b1;
    @(posedge i_mclk);
    #1 i_instr_valid = 1'b0;
    while (o_done !== 1'b1 && n < 10) begin
      seq = {seq[11:0], 2'(o_cycle_type), o_mem_lock, o_irq_inhibit};
      bz = bz & (o_busy === 1'b1);
      n++;
      @(posedge i_mclk);
      #1;
    end
    check({80'h0, seq, bz, o_busy}, {80'h0, exp_seq, 1'b1, 1'b0});
  endtask

  always @(posedge i_mclk) begin
    if (o_rd_we === 1'b1 || o_trap_valid === 1'b1) begin
      if (q.size() == 0) begin
        mismatches++;
        $display("unexpected at %0t: got %h expected %h", $time, o_rd_data, 32'h0);
      end else if (o_rd_we === 1'b1)
        check({30'h0, o_rd_idx, o_rd_data, 32'h0}, q.pop_front());
      else
        check({2'(o_trap_kind), o_trap_vector, o_supervisor_link_register, o_supervisor_saved_status},
              q.pop_front());
    end
    if (o_done === 1'b1)
      dones++;
  end

  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    logic [31:0] r, a, w, nw, rd, src;
    logic [3:0] rn, rm, di;
    logic [1:0] lane;
    logic b;
    for (int i = 0; i < 16; i++)
      u_mem.mem[i] = rnd();
    repeat (6) @(posedge i_mclk);
    #1 i_srst = 1'b0;
    for (int k = 0; k < 12; k++) begin
      prep();
      r = rnd();
      src = rnd();
      b = k[0];
      i_big_endian = k[1];
      abort_rd = (k == 9 || k == 11);
      abort_wr = (k >= 10);
      a = {26'h0, r[5:0]};
      w = u_mem.mem[a[5:2]];
      lane = i_big_endian ? ~a[1:0] : a[1:0];
      rd = b ? {24'h0, w[8*lane+:8]} : (w >> (8 * a[1:0])) | (w << (32 - 8 * a[1:0]));
      nw = b ? w : src;
      if (b)
        nw[8*lane+:8] = src[7:0];
      rn = r[11:8];
      rm = r[15:12];
      di = (k == 3) ? rm : r[19:16];
      i_base_register = a;
      i_source_register = src;
      if (k == 8)
        nw = w;
      else if (abort_rd | abort_wr)
        push_trap(sscx_pkg::SSCX_TRAP_ABT, ABORT_VEC, 32'h8);
      else
        q.push_back({30'h0, di, rd, 32'h0});
      run({(k == 8) ? 4'hf : 4'he, 5'h02, b, 2'h0, rn, di, 8'h09, rm}, (k == 8) ? 16'h0 : 16'hbbc4);
      if (!(abort_rd | abort_wr))
        check({66'h0, u_mem.mem[a[5:2]]}, {66'h0, nw});
    end
    abort_rd = 1'b0;
    abort_wr = 1'b0;
    $display("test swap done");
    for (int k = 0; k < 32; k++) begin
      prep();
      r = rnd();
      if (cond_ok(k[3:0], i_flags))
        push_trap(sscx_pkg::SSCX_TRAP_SVC, 32'h0000_0008, 32'h4);
      run({k[3:0], 4'hf, r[23:0]}, cond_ok(k[3:0], i_flags) ? 16'h0844 : 16'h0);
    end
    $display("test supervisor call done");
    for (int k = 0; k < 6; k++) begin
      prep();
      r = rnd();
      push_trap(sscx_pkg::SSCX_TRAP_UND, UNDEF_VEC, 32'h4);
      if (k % 3 == 2)
        run({4'he, 3'h6, r[24:0]}, 16'h0004);
      else
        run({4'he, 4'he, r[23:5], k % 3 == 1, r[3:0]}, 16'h0004);
    end
    $display("test coprocessor done");
    repeat (3) @(posedge i_mclk);
    #1;
    check({66'h0, 32'(q.size()), 32'(dones)}, {66'h0, 32'h0, 32'(runs)});
    stop_test();
  end
endmodule
